// [verilog/ssp_pkg.sv]
// ****************************************************************
// simple serial port constants
// ****************************************************************
package ssp_pkg;

  // register indices; byte address is four times the index
  localparam logic [3:0] IDX_CONTROL   = 4'hA;
  localparam logic [3:0] IDX_STATUS    = 4'hB;
  localparam logic [3:0] IDX_DATA      = 4'hC;
  localparam logic [3:0] IDX_PORT_DATA = 4'h1;
  localparam logic [3:0] IDX_PORT_DIR  = 4'h5;

  localparam logic [7:0] ADDR_CONTROL   = {2'h0, IDX_CONTROL, 2'h0};
  localparam logic [7:0] ADDR_STATUS    = {2'h0, IDX_STATUS, 2'h0};
  localparam logic [7:0] ADDR_DATA      = {2'h0, IDX_DATA, 2'h0};
  localparam logic [7:0] ADDR_PORT_DATA = {2'h0, IDX_PORT_DATA, 2'h0};
  localparam logic [7:0] ADDR_PORT_DIR  = {2'h0, IDX_PORT_DIR, 2'h0};

  // field positions
  localparam int CTL_ENABLE_BIT = 6;
  localparam int CTL_MASTER_BIT = 4;
  localparam int STS_DONE_BIT   = 7;
  localparam int STS_COLL_BIT   = 6;

  // shared pin positions in the port data and direction registers
  localparam int PIN_OUT = 0;
  localparam int PIN_IN  = 1;
  localparam int PIN_CLK = 2;
  localparam int PIN_CNT = 3;

  // reset values
  localparam logic [7:0]         BYTE_RESET = 8'h00;
  localparam logic [PIN_CNT-1:0] PINS_RESET = 3'h0;
  localparam logic [31:0]        WORD_ZERO  = 32'h0000_0000;

  // transfer timing
  localparam logic [3:0] BITCNT_ZERO   = 4'h0;
  localparam logic [3:0] BITCNT_ONE    = 4'h1;
  localparam logic [3:0] XFER_LAST_BIT = 4'h7;
  // master clock is bus clock / 4: phase 0,1 low, 2,3 high
  localparam int         SCK_DIV       = 4;
  localparam logic [1:0] PHASE_ZERO    = 2'h0;
  localparam logic [1:0] PHASE_ONE     = 2'h1;
  localparam int         PHASE_HIGH_BIT = 1;

  typedef enum logic [1:0] {
    SSP_IDLE  = 2'b01,
    SSP_SHIFT = 2'b10
  } ssp_state_t;

endpackage

// [verilog/ssp_top.sv]
// Operation
// - the shift clock idles high whenever no byte transfer runs
// - first falling clock edge starts a transfer and presents first bit
// - serial input is sampled on each rising clock edge
// - each later falling edge presents the next bit, shifted in at the rising edge before
// - a transfer is eight bits, ending at the eighth rising edge
// - master mode drives the clock pin at bus clock over four
// - build option picks msb-first or lsb-first for both directions
// - serial output shows last shift stage, first bit received
// - port data sets output level until the first transfer after enable; pin is ours after
// - enabling loads pin directions: out output, in input, clock
// - disabling aborts, clears bit count, pins revert, registers kept
// - reset clears enable and master bits
// - master mode: data write starts a transfer; data pins unchanged
// - master bit writable any time; clearing it aborts a transfer
// - completion flag sets at last rising edge of a byte
// - status read with flag set then data access clears completion
// - data access during a transfer sets the collision flag
// - collision clears the same way, or by disable then enable
// - one unbuffered data register for both directions
// - data register accessible only while the port is enabled
module ssp_top
  import ssp_pkg::*;
#(
  parameter bit MSB_FIRST = 1'b1
) (
  input  wire logic        mclk_in,
  input  wire logic        rst_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  input  wire logic        shared_output_port_pin_in,
  output logic             shared_output_port_pin_out,
  output logic             shared_output_port_pin_oe_n_out,
  input  wire logic        shared_input_port_pin_in,
  output logic             shared_input_port_pin_out,
  output logic             shared_input_port_pin_oe_n_out,
  input  wire logic        shared_clock_port_pin_in,
  output logic             shared_clock_port_pin_out,
  output logic             shared_clock_port_pin_oe_n_out
);

  localparam int OUT_POS = MSB_FIRST ? 7 : 0;
  localparam int INS_POS = MSB_FIRST ? 0 : 7;
  // the pin synchroniser lags two cycles, so a mode switch is masked
  // for three
  localparam logic [2:0] MODE_MASK_CLEAR = 3'h0;

  // ****************************************************************
  // bus decode
  // ****************************************************************
  logic       port_enable_bit_reg;
  logic       master_select_bit_reg;
  logic       hit_ctl;
  logic       hit_sts;
  logic       hit_data;
  logic       hit_pdat;
  logic       hit_pdir;
  logic       hit_any;
  logic       acc;
  logic       ctl_wr;
  logic       en_rise;
  logic       en_fall;
  logic       master_fall;
  logic       abort;
  logic       data_acc;
  logic       data_wr;
  logic       sts_rd;

  assign hit_ctl  = paddr_in == ADDR_CONTROL;
  assign hit_sts  = paddr_in == ADDR_STATUS;
  assign hit_data = paddr_in == ADDR_DATA;
  assign hit_pdat = paddr_in == ADDR_PORT_DATA;
  assign hit_pdir = paddr_in == ADDR_PORT_DIR;
  assign hit_any  = hit_ctl | hit_sts | hit_data | hit_pdat | hit_pdir;
  assign acc      = psel_in & penable_in;

  // zero wait states: every access completes in its first access cycle
  assign pready_out  = acc;
  assign pslverr_out = acc & ~hit_any;

  assign ctl_wr      = acc & pwrite_in & hit_ctl;
  assign en_rise     = ctl_wr & pwdata_in[CTL_ENABLE_BIT]
                       & ~port_enable_bit_reg;
  assign en_fall     = ctl_wr & ~pwdata_in[CTL_ENABLE_BIT]
                       & port_enable_bit_reg;
  assign master_fall = ctl_wr & ~pwdata_in[CTL_MASTER_BIT]
                       & master_select_bit_reg;
  assign abort       = en_fall | master_fall;
  assign data_acc    = acc & hit_data & port_enable_bit_reg;
  assign data_wr     = data_acc & pwrite_in;
  assign sts_rd      = acc & hit_sts & ~pwrite_in;

  // ****************************************************************
  // control register
  // ****************************************************************
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      port_enable_bit_reg   <= 1'b0;
      master_select_bit_reg <= 1'b0;
    end else if (ctl_wr) begin
      port_enable_bit_reg   <= pwdata_in[CTL_ENABLE_BIT];
      master_select_bit_reg <= pwdata_in[CTL_MASTER_BIT];
    end
  end

  // ****************************************************************
  // pin synchronisers and shift clock edges
  // ****************************************************************
  logic [PIN_CNT-1:0] pin_meta_reg;
  logic [PIN_CNT-1:0] pin_sync_reg;
  logic               sck_gen_reg;
  logic               sck_now;
  logic               sck_prev_reg;
  logic [2:0]         mode_chg_reg;
  logic               mode_mask;
  logic               sck_fall;
  logic               sck_rise;

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      pin_meta_reg <= PINS_RESET;
      pin_sync_reg <= PINS_RESET;
    end else begin
      pin_meta_reg <= {shared_clock_port_pin_in, shared_input_port_pin_in,
                       shared_output_port_pin_in};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // slave edges are only seen reliably up to bus clock / 4
  assign sck_now = master_select_bit_reg ? sck_gen_reg
                                         : pin_sync_reg[PIN_CLK];

  // a mode switch swaps the clock source; mask the false edge it makes
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      sck_prev_reg <= 1'b1;
      mode_chg_reg <= MODE_MASK_CLEAR;
    end else begin
      sck_prev_reg <= sck_now;
      mode_chg_reg <= {mode_chg_reg[1:0],
                       ctl_wr & (pwdata_in[CTL_MASTER_BIT]
                                 != master_select_bit_reg)};
    end
  end

  assign mode_mask = |mode_chg_reg;
  assign sck_fall  = port_enable_bit_reg & ~mode_mask
                     & sck_prev_reg & ~sck_now;
  assign sck_rise  = port_enable_bit_reg & ~mode_mask
                     & ~sck_prev_reg & sck_now;

  // ****************************************************************
  // transfer sequencer
  // ****************************************************************
  ssp_state_t state_reg;
  logic [3:0] bitcnt_reg;
  logic       done_pulse;

  assign done_pulse = (state_reg == SSP_SHIFT) & sck_rise
                      & (bitcnt_reg == XFER_LAST_BIT);

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      state_reg  <= SSP_IDLE;
      bitcnt_reg <= BITCNT_ZERO;
    end else if (abort || !port_enable_bit_reg) begin
      state_reg  <= SSP_IDLE;
      bitcnt_reg <= BITCNT_ZERO;
    end else begin
      case (state_reg)
        SSP_IDLE: begin
          if (sck_fall) begin
            state_reg  <= SSP_SHIFT;
            bitcnt_reg <= BITCNT_ZERO;
          end
        end
        SSP_SHIFT: begin
          if (done_pulse) begin
            state_reg  <= SSP_IDLE;
            bitcnt_reg <= BITCNT_ZERO;
          end else if (sck_rise) begin
            bitcnt_reg <= bitcnt_reg + BITCNT_ONE;
          end
        end
        default: begin
          state_reg  <= SSP_IDLE;
          bitcnt_reg <= BITCNT_ZERO;
        end
      endcase
    end
  end

  // ****************************************************************
  // shift register and serial output
  // ****************************************************************
  logic [7:0] shift_reg;
  logic       out_latch_reg;
  logic       xfer_seen_reg;
  logic       serial_out_level;

  // a write mid-transfer overwrites the byte outright; the
  // collision flag tells software the result is garbage
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      shift_reg <= BYTE_RESET;
    end else if (data_wr) begin
      shift_reg <= pwdata_in[7:0];
    end else if (state_reg == SSP_SHIFT && sck_rise) begin
      if (MSB_FIRST) begin
        shift_reg <= {shift_reg[6:0], pin_sync_reg[PIN_IN]};
      end else begin
        shift_reg <= {pin_sync_reg[PIN_IN], shift_reg[7:1]};
      end
    end
  end

  // output bit moves only on falling edges, though the register
  // shifts on rising ones
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      out_latch_reg <= 1'b0;
    end else if (sck_fall) begin
      out_latch_reg <= shift_reg[OUT_POS];
    end
  end

  // until the first transfer the level written to port data stands
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      xfer_seen_reg <= 1'b0;
    end else if (!port_enable_bit_reg) begin
      xfer_seen_reg <= 1'b0;
    end else if (sck_fall && !abort) begin
      xfer_seen_reg <= 1'b1;
    end
  end

  assign serial_out_level = (state_reg == SSP_SHIFT) ? out_latch_reg
                                                     : shift_reg[OUT_POS];

  // ****************************************************************
  // master clock generator
  // ****************************************************************
  logic       gen_run_reg;
  logic [1:0] phase_reg;
  logic [1:0] phase_next;
  logic       gen_start;

  assign gen_start  = data_wr & master_select_bit_reg
                      & (state_reg == SSP_IDLE) & ~gen_run_reg;
  assign phase_next = phase_reg + PHASE_ONE;

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      gen_run_reg <= 1'b0;
      phase_reg   <= PHASE_ZERO;
      sck_gen_reg <= 1'b1;
    end else if (abort || !port_enable_bit_reg || !master_select_bit_reg) begin
      gen_run_reg <= 1'b0;
      phase_reg   <= PHASE_ZERO;
      sck_gen_reg <= 1'b1;
    end else if (gen_start) begin
      gen_run_reg <= 1'b1;
      phase_reg   <= PHASE_ZERO;
      sck_gen_reg <= 1'b0;
    end else if (gen_run_reg) begin
      if (done_pulse) begin
        gen_run_reg <= 1'b0;
        phase_reg   <= PHASE_ZERO;
        sck_gen_reg <= 1'b1;
      end else begin
        phase_reg   <= phase_next;
        sck_gen_reg <= phase_next[PHASE_HIGH_BIT];
      end
    end
  end

  // ****************************************************************
  // status flags
  // ****************************************************************
  logic       done_flag_reg;
  logic       coll_flag_reg;
  logic       clr_arm_reg;
  logic       clr_seq;
  logic       coll_set;
  logic [31:0] prdata_reg;

  assign clr_seq  = data_acc & clr_arm_reg;
  assign coll_set = data_acc & (state_reg == SSP_SHIFT);

  // arm on the flag value software actually saw in the read data
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      clr_arm_reg <= 1'b0;
    end else if (sts_rd) begin
      clr_arm_reg <= prdata_reg[STS_DONE_BIT];
    end else if (data_acc) begin
      clr_arm_reg <= 1'b0;
    end
  end

  // set wins over clear in both flags
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      done_flag_reg <= 1'b0;
    end else if (done_pulse) begin
      done_flag_reg <= 1'b1;
    end else if (clr_seq) begin
      done_flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      coll_flag_reg <= 1'b0;
    end else if (coll_set) begin
      coll_flag_reg <= 1'b1;
    end else if (clr_seq || en_rise) begin
      coll_flag_reg <= 1'b0;
    end
  end

  // ****************************************************************
  // shared port data and direction
  // ****************************************************************
  logic [PIN_CNT-1:0] port_data_reg;
  logic [PIN_CNT-1:0] port_dir_reg;

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      port_data_reg <= PINS_RESET;
    end else if (acc && pwrite_in && hit_pdat) begin
      port_data_reg <= pwdata_in[PIN_CNT-1:0];
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      port_dir_reg <= PINS_RESET;
    end else if (en_rise) begin
      port_dir_reg[PIN_OUT] <= 1'b1;
      port_dir_reg[PIN_IN]  <= 1'b0;
      port_dir_reg[PIN_CLK] <= pwdata_in[CTL_MASTER_BIT];
    end else if (acc && pwrite_in && hit_pdir) begin
      port_dir_reg <= pwdata_in[PIN_CNT-1:0];
    end
  end

  // disabling hands pins back without touching data or direction
  assign shared_output_port_pin_out =
    (port_enable_bit_reg & xfer_seen_reg) ? serial_out_level
                                          : port_data_reg[PIN_OUT];
  assign shared_output_port_pin_oe_n_out = ~port_dir_reg[PIN_OUT];
  assign shared_input_port_pin_out       = port_data_reg[PIN_IN];
  assign shared_input_port_pin_oe_n_out  = ~port_dir_reg[PIN_IN];
  assign shared_clock_port_pin_out =
    (port_enable_bit_reg & master_select_bit_reg) ? sck_gen_reg
                                                  : port_data_reg[PIN_CLK];
  assign shared_clock_port_pin_oe_n_out =
    ~(port_dir_reg[PIN_CLK] | (port_enable_bit_reg
                               & master_select_bit_reg));

  // ****************************************************************
  // read data, captured in the setup cycle
  // ****************************************************************
  logic [31:0] rdata_next;

  always_comb begin
    rdata_next = WORD_ZERO;
    if (hit_ctl) begin
      rdata_next[CTL_ENABLE_BIT] = port_enable_bit_reg;
      rdata_next[CTL_MASTER_BIT] = master_select_bit_reg;
    end else if (hit_sts) begin
      rdata_next[STS_DONE_BIT] = done_flag_reg;
      rdata_next[STS_COLL_BIT] = coll_flag_reg;
    end else if (hit_data && port_enable_bit_reg) begin
      rdata_next[7:0] = shift_reg;
    end else if (hit_pdat) begin
      rdata_next[PIN_CNT-1:0] = port_data_reg;
    end else if (hit_pdir) begin
      rdata_next[PIN_CNT-1:0] = port_dir_reg;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      prdata_reg <= WORD_ZERO;
    end else if (psel_in && !penable_in && !pwrite_in) begin
      prdata_reg <= rdata_next;
    end
  end

  assign prdata_out = prdata_reg;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (rst_in);

  chk_idle_clk_high: assert property (
    port_enable_bit_reg && master_select_bit_reg && !gen_run_reg
    |-> shared_clock_port_pin_out && !shared_clock_port_pin_oe_n_out)
    else $error("master clock not high while idle");

  chk_first_fall: assert property (
    (state_reg == SSP_IDLE) && sck_fall && !abort
    |=> (state_reg == SSP_SHIFT) && (out_latch_reg == $past(shift_reg[OUT_POS])))
    else $error("first falling edge did not start transfer");

  chk_rise_sample: assert property (
    (state_reg == SSP_SHIFT) && sck_rise && !data_wr && !abort
    |=> shift_reg[INS_POS] == $past(pin_sync_reg[PIN_IN]))
    else $error("serial input not sampled on rising edge");

  chk_eighth_done: assert property (
    done_pulse |=> done_flag_reg && (state_reg == SSP_IDLE))
    else $error("completion flag missing after eighth edge");

  chk_gen_period: assert property (
    $fell(sck_gen_reg) |=> !sck_gen_reg ##1 sck_gen_reg ##1 sck_gen_reg)
    else $error("master clock period not two low two high");

  chk_abort_disable: assert property (
    en_fall |=> (state_reg == SSP_IDLE) && (bitcnt_reg == BITCNT_ZERO)
                && $stable(port_data_reg) && $stable(port_dir_reg))
    else $error("disable did not abort cleanly");

  chk_master_abort: assert property (
    master_fall |=> !gen_run_reg && (state_reg == SSP_IDLE))
    else $error("clearing master did not abort");

  chk_coll_set: assert property (
    data_acc && (state_reg == SSP_SHIFT) |=> coll_flag_reg)
    else $error("collision not flagged");

  chk_out_pin_idle: assert property (
    port_enable_bit_reg && xfer_seen_reg && (state_reg == SSP_IDLE)
    |-> shared_output_port_pin_out == shift_reg[OUT_POS])
    else $error("serial output not last shift stage");

  chk_out_pin_init: assert property (
    port_enable_bit_reg && !xfer_seen_reg
    |-> shared_output_port_pin_out == port_data_reg[PIN_OUT])
    else $error("serial output not at port data level");

  chk_data_gated: assert property (
    psel_in && !penable_in && !pwrite_in && hit_data && !port_enable_bit_reg
    |=> prdata_out == WORD_ZERO)
    else $error("data register readable while disabled");

  chk_enable_dirs: assert property (
    en_rise |=> port_dir_reg[PIN_OUT] && !port_dir_reg[PIN_IN])
    else $error("enable did not load pin directions");

  cov_master_byte: cover property (
    master_select_bit_reg && done_pulse);
  cov_slave_byte: cover property (
    !master_select_bit_reg && done_pulse);
  cov_collision: cover property (coll_set);
  cov_clear_seq: cover property (clr_seq && done_flag_reg);

endmodule

// [tb/ssp_remote.sv]
// ****************************************************************
// remote serial party: master on request, otherwise slave
// ****************************************************************
module ssp_remote (
  input  wire logic mclk_in,
  input  wire logic clk_line_in,
  input  wire logic sdo_in,
  output logic      sdi_out,
  output logic      clk_out,
  output logic      clk_oe_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] tx_reg;
  logic [7:0] rx_reg;
  initial begin
    sdi_out = 1'b1;
    clk_out = 1'b1;
    clk_oe_out = 1'b0;
    tx_reg = 8'h00;
  end
  task automatic load(input logic [7:0] b);
    tx_reg = b;
  endtask
  // msb first, new bit only at falling edges
  always @(negedge clk_line_in) begin
    sdi_out <= tx_reg[7];
    tx_reg <= {tx_reg[6:0], 1'b0};
  end
  always @(posedge clk_line_in) begin
    rx_reg <= {rx_reg[6:0], sdo_in};
    // after the hold time the line no longer shows the last bit
    repeat (2) @(posedge mclk_in);
    sdi_out <= ~sdi_out;
  end
  // half period in bus clocks; 2 is the fastest legal rate
  task automatic run(input logic [7:0] b, input int half);
    load(b);
    clk_oe_out <= 1'b1;
    repeat (8) begin
      clk_out <= 1'b0;
      repeat (half) @(posedge mclk_in);
      clk_out <= 1'b1;
      repeat (half) @(posedge mclk_in);
    end
    clk_oe_out <= 1'b0;
  endtask
endmodule

// [tb/tb.sv]
module tb
  import ssp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************************************
  // wiring
  // ****************************************************************
  logic        mclk_in;
  logic        rst_in;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        out_pin;
  logic        out_oe_n;
  logic        in_pin;
  logic        in_oe_n;
  logic        clk_pin;
  logic        clk_oe_n;
  logic        r_sdi;
  logic        r_clk;
  logic        r_oe;
  logic        clk_line;
  logic        sdi_line;
  logic        sdo_line;
  logic [31:0] rv;
  logic        ev;
  int          error_cnt;
  int          samples_checked;
  int          lows;
  // undriven clock line floats high through its pull-up
  assign clk_line = !clk_oe_n ? clk_pin : (r_oe ? r_clk : 1'b1);
  assign sdi_line = !in_oe_n ? in_pin : r_sdi;
  assign sdo_line = !out_oe_n ? out_pin : 1'b1;
  ssp_top u_ssp_top (
    .mclk_in(mclk_in), .rst_in(rst_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr),
    .shared_output_port_pin_in(sdo_line),
    .shared_output_port_pin_out(out_pin),
    .shared_output_port_pin_oe_n_out(out_oe_n),
    .shared_input_port_pin_in(sdi_line),
    .shared_input_port_pin_out(in_pin),
    .shared_input_port_pin_oe_n_out(in_oe_n),
    .shared_clock_port_pin_in(clk_line),
    .shared_clock_port_pin_out(clk_pin),
    .shared_clock_port_pin_oe_n_out(clk_oe_n)
  );
  ssp_remote u_ssp_remote (
    .mclk_in(mclk_in), .clk_line_in(clk_line), .sdo_in(sdo_line),
    .sdi_out(r_sdi), .clk_out(r_clk), .clk_oe_out(r_oe)
  );
  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("unexpected %s exp %h got %h", n, e, g);
      error_cnt++;
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge mclk_in);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk_in);
    penable <= 1'b1;
    @(posedge mclk_in);
    while (pready !== 1'b1) @(posedge mclk_in);
    rv = prdata;
    ev = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input string n);
    apb(1'b0, a, 32'h0000_0000);
    chk(n, e, rv);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic report_and_stop();
    if (error_cnt == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // ****************************************************************
  // clock, watchdog, tests
  // ****************************************************************
  initial begin
    mclk_in = 1'b0;
    forever #25 mclk_in = ~mclk_in;
  end
  initial begin
    repeat (3000) @(posedge mclk_in);
    error_cnt++;
    report_and_stop();
  end
  initial begin
    rst_in = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    error_cnt = 0;
    samples_checked = 0;
    repeat (4) @(posedge mclk_in);
    rst_in <= 1'b0;
    rd(ADDR_CONTROL, 32'h0, "control");
    rd(ADDR_STATUS, 32'h0, "status");
    wr(ADDR_DATA, 32'h77);
    wr(ADDR_PORT_DATA, 32'h3);
    wr(ADDR_PORT_DIR, 32'h1);
    @(posedge mclk_in);
    chk("port pins", 32'h3, {30'h0, in_pin, out_pin});
    wr(ADDR_CONTROL, 32'h40);
    @(posedge mclk_in);
    chk("dirs", 32'h6, {29'h0, clk_oe_n, in_oe_n, out_oe_n});
    chk("out pin", 32'h1, {31'h0, out_pin});
    rd(ADDR_DATA, 32'h0, "data");
    // collision without completion, then abort by disable
    fork
      u_ssp_remote.run(8'h00, 5);
      begin
        repeat (25) @(posedge mclk_in);
        wr(ADDR_DATA, 32'h33);
        rd(ADDR_STATUS, 32'h40, "status");
        wr(ADDR_CONTROL, 32'h0);
      end
    join
    wr(ADDR_CONTROL, 32'h40);
    rd(ADDR_STATUS, 32'h0, "status");
    // tx last bit differs from rx first bit to expose the idle level
    wr(ADDR_DATA, 32'hA4);
    u_ssp_remote.run(8'h96, 5);
    repeat (6) @(posedge mclk_in);
    chk("remote rx", 32'hA4, {24'h0, u_ssp_remote.rx_reg});
    chk("idle out", 32'h1, {31'h0, sdo_line});
    rd(ADDR_STATUS, 32'h80, "status");
    rd(ADDR_DATA, 32'h96, "data");
    rd(ADDR_STATUS, 32'h0, "status");
    fork
      u_ssp_remote.run(8'h5A, 5);
      begin
        repeat (30) @(posedge mclk_in);
        apb(1'b0, ADDR_DATA, 32'h0);
      end
    join
    repeat (6) @(posedge mclk_in);
    rd(ADDR_STATUS, 32'hC0, "status");
    apb(1'b0, ADDR_DATA, 32'h0);
    rd(ADDR_STATUS, 32'h0, "status");
    wr(ADDR_CONTROL, 32'h50);
    @(posedge mclk_in);
    chk("clk drive", 32'h0, {31'h0, clk_oe_n});
    u_ssp_remote.load(8'hC3);
    wr(ADDR_DATA, 32'h5A);
    lows = 0;
    repeat (40) begin
      @(posedge mclk_in);
      if (clk_line === 1'b0)
        lows++;
    end
    chk("clock lows", 32'h10, lows);
    chk("clock idle", 32'h1, {31'h0, clk_line});
    chk("remote rx", 32'h5A, {24'h0, u_ssp_remote.rx_reg});
    rd(ADDR_STATUS, 32'h80, "status");
    rd(ADDR_DATA, 32'hC3, "data");
    wr(ADDR_DATA, 32'h11);
    repeat (8) @(posedge mclk_in);
    wr(ADDR_CONTROL, 32'h40);
    repeat (40) @(posedge mclk_in);
    rd(ADDR_STATUS, 32'h0, "status");
    wr(ADDR_CONTROL, 32'h0);
    rd(ADDR_DATA, 32'h0, "data");
    rd(8'h3C, 32'h0, "unmapped");
    chk("slave error", 32'h1, {31'h0, ev});
    report_and_stop();
  end
endmodule
